// File: verilog/via_regs.svh
// constants of the interrupt acknowledge block
`ifndef VIA_REGS_SVH
`define VIA_REGS_SVH
`define VIA_NREQ        8
`define VIA_NREQ_W      3
`define VIA_PSW_RESET   8'h02
`define VIA_PSW_IE      7
`define VIA_PSW_ISP     1
`define VIA_BRK_VEC     16'h003e
`define VIA_VEC_BASE    16'h0004
`define VIA_NMI_VEC     16'h0002
`define VIA_TMIN_HI     6'h07
`define VIA_TMIN_LO     6'h08
`define VIA_TMAX_HI     6'h20
`define VIA_TMAX_LO     6'h21
`define VIA_ADR_IF      4'h0
`define VIA_ADR_MK      4'h1
`define VIA_ADR_PR      4'h2
`define VIA_ADR_PSW     4'h3
`define VIA_ADR_TEST    4'h4
`define VIA_ADR_STAT    4'h5
`define VIA_ADR_VEC     4'h6
`endif

// File: verilog/via_pkg.sv
// types of the interrupt acknowledge block
`default_nettype none
package via_pkg;
  typedef enum logic [1:0] {
    VIA_SVC_NONE = 2'b00,
    VIA_SVC_MASK = 2'b01,
    VIA_SVC_BRK  = 2'b10,
    VIA_SVC_NMI  = 2'b11
  } via_svc_type;
  typedef enum logic [1:0] {
    VIA_ST_RUN  = 2'b00,
    VIA_ST_HOLD = 2'b01,
    VIA_ST_ONE  = 2'b10
  } via_state_type;
endpackage
`default_nettype wire

// File: verilog/via_ack.sv
// interrupt acknowledge and priority logic
`include "via_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module via_ack (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        arst_n,
  // register port
  input  wire logic [3:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  // request sources, one-cycle events from logic on clk_sys; key_pin is a pin level synchronised here
  input  wire logic [`VIA_NREQ-1:0]        req_event,
  input  wire logic                        nmi_event,
  input  wire logic                        watch_overflow_test_input,
  input  wire logic                        key_pin,
  // instruction sequencer
  input  wire logic                        instr_boundary,
  input  wire logic                        instr_hold,
  input  wire logic                        break_instr,
  input  wire logic                        vectored_return_instr,
  input  wire logic                        break_return_instr,
  input  wire logic                        status_pop,
  input  wire logic [7:0]                  status_pop_data,
  input  wire logic                        accept_on_instr,
  input  wire logic                        accept_off_instr,
  // acknowledge outputs
  output logic                             ack_take,
  output logic      [15:0]                 ack_vector,
  output logic      [7:0]                  push_status,
  output logic                             push_strobe,
  output logic                             standby_release,
  output via_pkg::via_svc_type             svc_kind
);
  import via_pkg::*;

  logic [`VIA_NREQ-1:0] request_flag_ff, mask_flag_ff, level_choice_ff;
  logic [7:0]           status_word_ff;
  logic                 nmi_pend_ff, nmi_svc_ff;
  logic [1:0]           test_flag_ff, test_mask_ff;
  logic                 key_s1_ff, key_s2_ff, key_prev_ff;
  logic                 release_ff, take_ff, push_ff;
  logic [15:0]          vec_ff;
  logic [7:0]           push_ff_data;
  logic [7:0]           rdata_ff;
  via_svc_type          svc_ff;
  via_state_type        state_ff, nxt_state;

  function automatic logic [`VIA_NREQ_W:0] pick_first(input logic [`VIA_NREQ-1:0] v);
    logic [`VIA_NREQ_W:0] r;
    r = '0;
    for (int i = `VIA_NREQ - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, i[`VIA_NREQ_W-1:0]};
      end
    end
    return r;
  endfunction

  wire maskable_accept_enable  = status_word_ff[`VIA_PSW_IE];
  wire serviced_priority_level = status_word_ff[`VIA_PSW_ISP];
  wire [`VIA_NREQ-1:0] eligible = request_flag_ff & ~mask_flag_ff;
  // low level needs isp=1, high level always passes the level test
  wire [`VIA_NREQ-1:0] lvl_ok = ~level_choice_ff | {`VIA_NREQ{serviced_priority_level}};
  wire [`VIA_NREQ-1:0] cand = eligible & lvl_ok;
  wire [`VIA_NREQ_W:0] pick_hi = pick_first(cand & ~level_choice_ff);
  wire [`VIA_NREQ_W:0] pick_lo = pick_first(cand & level_choice_ff);
  wire [`VIA_NREQ_W:0] pick = pick_hi[`VIA_NREQ_W] ? pick_hi : pick_lo;
  wire decide  = instr_boundary && (state_ff == VIA_ST_RUN) && !break_instr;
  wire take_nmi = decide && nmi_pend_ff && !nmi_svc_ff;
  wire take_msk = decide && !take_nmi && !nmi_svc_ff && maskable_accept_enable
                  && pick[`VIA_NREQ_W];
  wire take_brk = break_instr && instr_boundary;
  wire any_take = take_nmi || take_msk || take_brk;
  wire any_ret  = vectored_return_instr || break_return_instr;
  wire key_fall = key_prev_ff && !key_s2_ff;
  wire [`VIA_NREQ-1:0] take_bit = take_msk ? (`VIA_NREQ'(1) << pick[`VIA_NREQ_W-1:0]) : '0;
  wire wr_if  = reg_wr && (reg_addr == `VIA_ADR_IF);
  wire wr_tst = reg_wr && (reg_addr == `VIA_ADR_TEST);
  wire rd_hold = (reg_wr || reg_rd) && (reg_addr <= `VIA_ADR_PSW);
  wire psw_touch = accept_on_instr || accept_off_instr || any_ret || status_pop;
  // helpers for the order checks
  wire [`VIA_NREQ_W-1:0] pick_idx   = pick[`VIA_NREQ_W-1:0];
  wire                   pick_level = level_choice_ff[pick_idx];
  wire [`VIA_NREQ-1:0]   pick_below = (`VIA_NREQ'(1) << pick_idx) - `VIA_NREQ'(1);
  wire [`VIA_NREQ-1:0]   pick_peers = pick_level ? level_choice_ff : ~level_choice_ff;

  // defer windows: hold instr, return, status word op or access to registers 0-3, then one instruction must finish
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      VIA_ST_RUN:  if (instr_hold || psw_touch || rd_hold) nxt_state = VIA_ST_HOLD;
      // one whole instruction runs before decisions resume
      VIA_ST_HOLD: if (instr_boundary) nxt_state = VIA_ST_RUN;
      VIA_ST_ONE:  if (instr_boundary) nxt_state = VIA_ST_RUN;
      default:     nxt_state = VIA_ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) state_ff <= VIA_ST_RUN;
    else         state_ff <= nxt_state;
  end

  // set wins over software clear and over accept clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      request_flag_ff <= '0;
    end else begin
      request_flag_ff <= ((wr_if ? reg_wdata : request_flag_ff) & ~take_bit) | req_event;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mask_flag_ff    <= '1;
      level_choice_ff <= '1;
    end else begin
      if (reg_wr && reg_addr == `VIA_ADR_MK) mask_flag_ff <= reg_wdata;
      if (reg_wr && reg_addr == `VIA_ADR_PR) level_choice_ff <= reg_wdata;
    end
  end

  // status word: accept clears enable, returns restore from stack
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      status_word_ff <= `VIA_PSW_RESET;
    end else if (any_take) begin
      status_word_ff[`VIA_PSW_IE] <= 1'b0;
      if (take_msk) status_word_ff[`VIA_PSW_ISP] <= level_choice_ff[pick[`VIA_NREQ_W-1:0]];
      if (take_nmi) status_word_ff[`VIA_PSW_ISP] <= 1'b0;
    end else if (any_ret || status_pop) begin
      status_word_ff <= status_pop_data;
    end else if (reg_wr && reg_addr == `VIA_ADR_PSW) begin
      status_word_ff <= reg_wdata;
    end else if (accept_on_instr) begin
      status_word_ff[`VIA_PSW_IE] <= 1'b1;
    end else if (accept_off_instr) begin
      status_word_ff[`VIA_PSW_IE] <= 1'b0;
    end
  end

  // nmi pends once; service ends on vectored return
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      nmi_pend_ff <= 1'b0;
      nmi_svc_ff  <= 1'b0;
    end else begin
      nmi_pend_ff <= nmi_event || (nmi_pend_ff && !take_nmi);
      if (take_nmi) nmi_svc_ff <= 1'b1;
      else if (vectored_return_instr) nmi_svc_ff <= 1'b0;
    end
  end

  // acknowledge strobe and vector; test events never come through here
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      take_ff      <= 1'b0;
      push_ff      <= 1'b0;
      vec_ff       <= '0;
      push_ff_data <= '0;
      svc_ff       <= VIA_SVC_NONE;
    end else begin
      take_ff      <= any_take;
      push_ff      <= any_take;
      push_ff_data <= status_word_ff;
      if (take_brk)      vec_ff <= `VIA_BRK_VEC;
      else if (take_nmi) vec_ff <= `VIA_NMI_VEC;
      else if (take_msk) vec_ff <= `VIA_VEC_BASE + {11'h000, pick[`VIA_NREQ_W-1:0], 1'b0};
      if (take_brk)      svc_ff <= VIA_SVC_BRK;
      else if (take_nmi) svc_ff <= VIA_SVC_NMI;
      else if (take_msk) svc_ff <= VIA_SVC_MASK;
      else if (any_ret)  svc_ff <= VIA_SVC_NONE;
    end
  end

  // key pin synchroniser and falling edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      key_s1_ff   <= 1'b1;
      key_s2_ff   <= 1'b1;
      key_prev_ff <= 1'b1;
    end else begin
      key_s1_ff   <= key_pin;
      key_s2_ff   <= key_s1_ff;
      key_prev_ff <= key_s2_ff;
    end
  end

  // test flags: bit0 watch, bit1 key; masks reset to 1
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      test_flag_ff <= '0;
      test_mask_ff <= '1;
      release_ff   <= 1'b0;
    end else begin
      test_flag_ff <= ((wr_tst ? reg_wdata[1:0] : test_flag_ff))
                      | {key_fall, watch_overflow_test_input};
      if (wr_tst) test_mask_ff <= reg_wdata[5:4];
      release_ff <= (watch_overflow_test_input && !test_mask_ff[0])
                    || (key_fall && !test_mask_ff[1]);
    end
  end

  wire [7:0] rd_mux = (reg_addr == `VIA_ADR_IF)   ? request_flag_ff :
                      (reg_addr == `VIA_ADR_MK)   ? mask_flag_ff :
                      (reg_addr == `VIA_ADR_PR)   ? level_choice_ff :
                      (reg_addr == `VIA_ADR_PSW)  ? status_word_ff :
                      (reg_addr == `VIA_ADR_TEST) ? {2'b00, test_mask_ff, 2'b00, test_flag_ff} :
                      (reg_addr == `VIA_ADR_STAT) ? {2'b00, svc_ff, nmi_svc_ff, nmi_pend_ff, state_ff} :
                      (reg_addr == `VIA_ADR_VEC)  ? vec_ff[7:0] : 8'h00;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) rdata_ff <= '0;
    else if (reg_rd) rdata_ff <= rd_mux;
  end

  assign reg_rdata       = rdata_ff;
  assign ack_take        = take_ff;
  assign ack_vector      = vec_ff;
  assign push_status     = push_ff_data;
  assign push_strobe     = push_ff;
  assign standby_release = release_ff;
  assign svc_kind        = svc_ff;

  // latency bound helper: cycles since an eligible request began waiting
  logic [5:0] wait_cnt_ff;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) wait_cnt_ff <= '0;
    else if (any_take || !(|eligible)) wait_cnt_ff <= '0;
    else if (wait_cnt_ff != 6'h3f) wait_cnt_ff <= wait_cnt_ff + 6'h01;
  end

  mask_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take_msk |-> eligible[pick[`VIA_NREQ_W-1:0]]) else $error("masked request taken");
  enable_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take_msk |-> maskable_accept_enable) else $error("taken while disabled");
  level_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take_msk && !serviced_priority_level |-> !level_choice_ff[pick[`VIA_NREQ_W-1:0]])
    else $error("low level taken in high service");
  nmi_block_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    nmi_svc_ff |-> !(take_msk || take_nmi)) else $error("nesting in nmi service");
  enable_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    any_take |=> !maskable_accept_enable && ack_take && push_strobe) else $error("accept effects");
  brk_vector_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take_brk |=> ack_vector == `VIA_BRK_VEC) else $error("break vector wrong");
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take_msk && !req_event[pick[`VIA_NREQ_W-1:0]] && !wr_if
    |=> !request_flag_ff[$past(pick[`VIA_NREQ_W-1:0])]) else $error("flag not cleared");
  hold_defer_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    state_ff != VIA_ST_RUN |-> !(take_msk || take_nmi)) else $error("taken in defer");
  // checked one edge later: the first edge in reset still sees an unset word
  reset_psw_a: assert property (@(posedge clk_sys)
    !arst_n |=> status_word_ff == `VIA_PSW_RESET) else $error("reset status word");
  release_mask_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    standby_release |-> $past(!test_mask_ff[0] || !test_mask_ff[1])) else $error("release masked");
  test_novec_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    watch_overflow_test_input && !any_take |=> test_flag_ff[0] && !ack_take) else $error("test");

  hi_first_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take_msk && |(cand & ~level_choice_ff) |-> !pick_level)
    else $error("low level chosen over high");

  order_low_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take_msk |-> !(|(cand & pick_below & pick_peers)))
    else $error("higher index chosen first");

  brk_always_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    break_instr && instr_boundary |=> ack_take && svc_kind == VIA_SVC_BRK)
    else $error("break not taken");

  push_word_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    any_take |=> push_status == $past(status_word_ff))
    else $error("pushed status wrong");

  isp_copy_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take_msk |=> serviced_priority_level == $past(pick_level))
    else $error("level not copied");

  vec_map_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take_msk && !take_brk |=> ack_vector == `VIA_VEC_BASE + {11'h000, $past(pick_idx), 1'b0})
    else $error("maskable vector wrong");

  ret_restore_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (any_ret || status_pop) && !any_take |=> status_word_ff == $past(status_pop_data))
    else $error("status word not restored");

  nmi_vec_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take_nmi && !take_brk |=> svc_kind == VIA_SVC_NMI && ack_vector == `VIA_NMI_VEC)
    else $error("nmi vector wrong");

  key_release_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    key_fall && !test_mask_ff[1] |=> standby_release && test_flag_ff[1])
    else $error("key event lost");

  pend_keep_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !wr_if |=> ($past(request_flag_ff & ~take_bit) & ~request_flag_ff) == '0)
    else $error("pending request lost");

  no_push_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !any_take |=> !push_strobe && !ack_take)
    else $error("push without accept");

  cov_mask_c: cover property (@(posedge clk_sys) disable iff (!arst_n) take_msk);
  cov_nest_c: cover property (@(posedge clk_sys) disable iff (!arst_n) take_msk && svc_ff == VIA_SVC_MASK);
  cov_brk_c:  cover property (@(posedge clk_sys) disable iff (!arst_n) take_brk);
  cov_nmi_c:  cover property (@(posedge clk_sys) disable iff (!arst_n) take_nmi ##[1:40] vectored_return_instr);
  cov_wait_c: cover property (@(posedge clk_sys) disable iff (!arst_n)
    take_msk && wait_cnt_ff >= `VIA_TMIN_HI);
endmodule
`default_nettype wire

// File: verification/via_seq_model.sv
// instruction sequencer model facing the acknowledge block
`timescale 1ns/1ps
`default_nettype none
module via_seq_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // bench control: op 1 break,2 vret,3 bret,4 pop,5 on,6 off
  input  wire logic       slow,
  input  wire logic [2:0] cmd,
  input  wire logic       go,
  input  wire logic [7:0] pop_val,
  // sequencer side
  output logic            instr_boundary,
  output logic            instr_hold,
  output logic            break_instr,
  output logic            vectored_return_instr,
  output logic            break_return_instr,
  output logic            status_pop,
  output logic      [7:0] status_pop_data,
  output logic            accept_on_instr,
  output logic            accept_off_instr,
  output logic            done
);
  logic [1:0] cnt_ff;
  logic [2:0] op_ff;
  logic       pend_ff;
  logic       issue;
  assign instr_boundary        = (cnt_ff == 2'h0);
  assign issue                 = instr_boundary & pend_ff;
  // break is no hold instruction
  assign instr_hold            = issue & (op_ff != 3'h1);
  assign break_instr           = issue & (op_ff == 3'h1);
  assign vectored_return_instr = issue & (op_ff == 3'h2);
  assign break_return_instr    = issue & (op_ff == 3'h3);
  assign status_pop            = issue & (op_ff == 3'h4);
  assign accept_on_instr       = issue & (op_ff == 3'h5);
  assign accept_off_instr      = issue & (op_ff == 3'h6);
  assign done                  = issue;
  // stale stack data inverted so a late sample shows
  assign status_pop_data = (issue & (op_ff inside {3'h2, 3'h3, 3'h4})) ? pop_val : ~pop_val;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff  <= 2'h0;
      op_ff   <= 3'h0;
      pend_ff <= 1'h0;
    end else begin
      cnt_ff  <= instr_boundary ? {slow, 1'h0} : cnt_ff - 2'h1;
      pend_ff <= go | (pend_ff & ~instr_boundary);
      op_ff   <= go ? cmd : op_ff;
    end
  end
endmodule
`default_nettype wire

// File: verification/via_ack_tb.sv
// self-checking bench for the interrupt acknowledge block
`include "via_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module via_ack_tb;
  import via_pkg::*;
  logic        clk_sys = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic        nmi_event = 1'h0, wt = 1'h0, key_pin = 1'h1, slow = 1'h0, go = 1'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, req_event = 8'h00, pop_val = 8'h00, pr, lv;
  logic [2:0]  cmd = 3'h0, a, b, w;
  logic [7:0]  reg_rdata, push_status, status_pop_data, l_ps;
  logic [15:0] ack_vector, l_vec;
  logic        ack_take, push_strobe, standby_release, done, instr_boundary, instr_hold;
  logic        break_instr, vectored_return_instr, break_return_instr, status_pop;
  logic        accept_on_instr, accept_off_instr;
  via_svc_type svc_kind, l_kind;
  int          n_mismatch = 0, checks = 0, n_ack = 0, n_bnd = 0, ack_bnd = 0, n_rel = 0;
  int          b0, s, k;
  always #12.5 clk_sys = ~clk_sys;
  via_ack via_ack_inst (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .req_event, .nmi_event, .watch_overflow_test_input(wt), .key_pin, .instr_boundary,
    .instr_hold, .break_instr, .vectored_return_instr, .break_return_instr, .status_pop,
    .status_pop_data, .accept_on_instr, .accept_off_instr, .ack_take, .ack_vector,
    .push_status, .push_strobe, .standby_release, .svc_kind);
  via_seq_model via_seq_model_inst (.clk_sys, .arst_n, .slow, .cmd, .go, .pop_val,
    .instr_boundary, .instr_hold, .break_instr, .vectored_return_instr, .break_return_instr,
    .status_pop, .status_pop_data, .accept_on_instr, .accept_off_instr, .done);
  always @(posedge clk_sys) begin
    if (ack_take === 1'h1) begin
      n_ack++;
      ack_bnd = n_bnd;
      l_vec = ack_vector;
      l_kind = svc_kind;
      l_ps = push_strobe === 1'h1 ? push_status : 8'hxx;
    end
    if (instr_boundary === 1'h1) n_bnd++;
    if (standby_release === 1'h1) n_rel++;
  end
  task automatic cmp8(string nm, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp16(string nm, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(logic [3:0] ad, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1; reg_addr <= ad; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic rchk(logic [3:0] ad, logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'h1; reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 cmp8("register", e, reg_rdata);
  endtask
  task automatic pulse(logic [7:0] r, logic n, logic t);
    @(posedge clk_sys);
    req_event <= r; nmi_event <= n; wt <= t;
    @(posedge clk_sys);
    req_event <= 8'h00; nmi_event <= 1'h0; wt <= 1'h0;
  endtask
  // sequencer runs the op at its next boundary
  task automatic run(logic [2:0] c, logic [7:0] p);
    @(posedge clk_sys);
    cmd <= c; go <= 1'h1; pop_val <= p;
    @(posedge clk_sys);
    go <= 1'h0;
    #1 for (int i = 0; i < 9 && done !== 1'h1; i++) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1 b0 = n_bnd;
  endtask
  task automatic expect_ack(logic [15:0] v, via_svc_type kd, logic [7:0] ps);
    s = n_ack;
    for (int i = 0; i < 80 && n_ack == s; i++) @(posedge clk_sys) #1;
    cmp16("vector", v, n_ack == s ? 16'hxxxx : l_vec);
    cmp8("kind", {6'h00, kd}, {6'h00, l_kind});
    cmp8("pushed status", ps, l_ps);
  endtask
  task automatic no_ack(int n);
    s = n_ack;
    tick(n);
    cmp8("accept count", s[7:0], n_ack[7:0]);
  endtask
  // higher level first, then lowest index
  function automatic logic [2:0] win(logic [7:0] p, logic [7:0] l);
    logic [2:0] r = 3'h0;
    for (int i = 7; i >= 0; i--) if (p[i]) r = i[2:0];
    for (int i = 7; i >= 0; i--) if (p[i] && !l[i]) r = i[2:0];
    return r;
  endfunction
  function automatic logic [15:0] vec(logic [2:0] i);
    return `VIA_VEC_BASE + {12'h000, i, 1'h0};
  endfunction
  initial begin
    tick(20000);
    n_mismatch++;
    final_report;
  end
  initial begin
    void'($urandom(32'h1bc3cd62));
    tick(10);
    arst_n <= 1'h1;
    rchk(`VIA_ADR_MK, 8'hff);
    rchk(`VIA_ADR_PR, 8'hff);
    rchk(`VIA_ADR_PSW, `VIA_PSW_RESET);
    rchk(`VIA_ADR_TEST, 8'h30);
    rchk(4'hf, 8'h00);
    pulse(8'h08, 1'h0, 1'h0);
    no_ack(30);
    wr(`VIA_ADR_MK, 8'h00);
    no_ack(30);
    rchk(`VIA_ADR_IF, 8'h08);
    wr(`VIA_ADR_PSW, 8'h82);
    expect_ack(16'h000a, VIA_SVC_MASK, 8'h82);
    rchk(`VIA_ADR_IF, 8'h00);
    rchk(`VIA_ADR_PSW, 8'h02);
    run(3'h5, 8'h00);
    pulse(8'h20, 1'h0, 1'h0);
    expect_ack(16'h000e, VIA_SVC_MASK, 8'h82);
    wr(`VIA_ADR_PR, 8'hfe);
    wr(`VIA_ADR_PSW, 8'h80);
    pulse(8'h10, 1'h0, 1'h0);
    no_ack(30);
    pulse(8'h01, 1'h0, 1'h0);
    expect_ack(16'h0004, VIA_SVC_MASK, 8'h80);
    wr(`VIA_ADR_PSW, 8'h82);
    expect_ack(16'h000c, VIA_SVC_MASK, 8'h82);
    for (k = 0; k < 10; k++) begin
      lv = $urandom;
      a = $urandom;
      b = a + 3'h1 + 3'($urandom % 7);
      pr = (8'h01 << a) | (8'h01 << b);
      @(posedge clk_sys) slow <= k[0];
      wr(`VIA_ADR_PR, lv);
      wr(`VIA_ADR_PSW, 8'h82);
      pulse(pr, 1'h0, 1'h0);
      w = win(pr, lv);
      expect_ack(vec(w), VIA_SVC_MASK, 8'h82);
      wr(`VIA_ADR_PSW, 8'h82);
      expect_ack(vec(win(pr & ~(8'h01 << w), lv)), VIA_SVC_MASK, 8'h82);
    end
    wr(`VIA_ADR_PSW, 8'h82);
    run(3'h1, 8'h00);
    expect_ack(`VIA_BRK_VEC, VIA_SVC_BRK, 8'h82);
    rchk(`VIA_ADR_PSW, 8'h02);
    pulse(8'h40, 1'h1, 1'h0);
    expect_ack(`VIA_NMI_VEC, VIA_SVC_NMI, 8'h02);
    run(3'h5, 8'h00);
    pulse(8'h00, 1'h1, 1'h0);
    no_ack(40);
    run(3'h2, 8'h00);
    expect_ack(`VIA_NMI_VEC, VIA_SVC_NMI, 8'h00);
    cmp8("boundaries", 8'h02, 8'(ack_bnd - b0));
    run(3'h2, 8'h82);
    expect_ack(16'h0010, VIA_SVC_MASK, 8'h82);
    run(3'h3, 8'h42);
    rchk(`VIA_ADR_PSW, 8'h42);
    run(3'h4, 8'hc2);
    rchk(`VIA_ADR_PSW, 8'hc2);
    run(3'h6, 8'h00);
    rchk(`VIA_ADR_PSW, 8'h42);
    s = n_rel;
    b0 = n_ack;
    pulse(8'h00, 1'h0, 1'h1);
    tick(6);
    cmp8("release count", s[7:0], n_rel[7:0]);
    wr(`VIA_ADR_TEST, 8'h00);
    pulse(8'h00, 1'h0, 1'h1);
    tick(6);
    cmp8("release count", 8'(s + 1), n_rel[7:0]);
    @(posedge clk_sys) key_pin <= 1'h0;
    tick(8);
    cmp8("release count", 8'(s + 2), n_rel[7:0]);
    rchk(`VIA_ADR_TEST, 8'h03);
    cmp8("accept count", b0[7:0], n_ack[7:0]);
    final_report;
  end
endmodule
`default_nettype wire
